// ### rtl/sac_pkg.sv
`default_nettype none
package sac_pkg;
	// register offsets on the byte-wide register port
	localparam logic [7:0] ADDR_CTL_ONE  = 8'h1c;
	localparam logic [7:0] ADDR_CTL_TWO  = 8'h1d;
	localparam logic [7:0] ADDR_STATUS   = 8'h1e;
	localparam logic [7:0] ADDR_RES_HIGH = 8'h1f;

	// conversion_control_one fields
	localparam int C1_START_BIT = 7;
	localparam int C1_MODE_LSB  = 5;
	localparam int C1_INDIS_BIT = 4;
	localparam int C1_CHAN_LSB  = 0;
	// conversion_control_two fields
	localparam int C2_LADDER_BIT = 5;
	localparam int C2_TIME_LSB   = 1;
	// conversion_status_low_result fields
	localparam int ST_LOW_LSB  = 6;
	localparam int ST_EOC_BIT  = 5;
	localparam int ST_BUSY_BIT = 4;

	localparam logic [7:0] CTL_ONE_RST = 8'h10;
	localparam logic [7:0] CTL_TWO_RST = 8'h00;

	localparam int RES_BITS     = 10;
	localparam int SAMPLE_STEPS = 3;
	localparam int SAR_STEPS    = 13;
	localparam int PER_W        = 7;

	// conversion times in system clock periods
	localparam int CONV_CYC_0 = 39;
	localparam int CONV_CYC_2 = 78;
	localparam int CONV_CYC_3 = 156;
	localparam int CONV_CYC_4 = 312;
	localparam int CONV_CYC_5 = 624;
	localparam int CONV_CYC_6 = 1248;

	typedef enum logic [1:0] {
		MODE_OFF    = 2'b00,
		MODE_SINGLE = 2'b01,
		MODE_RSVD   = 2'b10,
		MODE_REPEAT = 2'b11
	} sac_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CONV = 2'b10
	} sac_state_t;

	// cycles per sequencer step; every time is an exact multiple of the step count
	function automatic logic [PER_W-1:0] sac_period(input logic [2:0] code);
		int cyc;
		case (code)
			3'b000: cyc = CONV_CYC_0;
			3'b010: cyc = CONV_CYC_2;
			3'b011: cyc = CONV_CYC_3;
			3'b100: cyc = CONV_CYC_4;
			3'b101: cyc = CONV_CYC_5;
			default: cyc = CONV_CYC_6;
		endcase
		return PER_W'(cyc / SAR_STEPS);
	endfunction
endpackage
`default_nettype wire

// ### rtl/sac_conv_if.sv
`default_nettype none
interface sac_conv_if;
	logic       run;
	logic [6:0] period;
	logic       step;
	logic [3:0] step_idx;
	logic       done;
	logic       cmp_bit;
	logic [9:0] trial;
	logic [9:0] final_code;
	logic       sampling;

	modport pace (input run, period, output step, step_idx, done);
	modport sar (input run, step, step_idx, cmp_bit, output trial, final_code, sampling);
	modport ctl (output run, period, cmp_bit,
		input step, step_idx, done, trial, final_code, sampling);
endinterface
`default_nettype wire

// ### rtl/sac_pace.sv
`default_nettype none
module sac_pace
	import sac_pkg::*;
(
	// clock and reset
	input  wire logic      sys_clk,
	input  wire logic      resetn,
	// sequencer timing
	sac_conv_if.pace       cv
);
	logic [6:0] cnt_reg;
	logic [6:0] cnt_next;
	logic [3:0] idx_reg;
	logic [3:0] idx_next;

	assign cv.step     = cv.run && (cnt_reg == cv.period - 7'h01);
	assign cv.done     = cv.step && (idx_reg == 4'(SAR_STEPS - 1));
	assign cv.step_idx = idx_reg;

	// counters rest at zero outside a conversion so every start is aligned
	assign cnt_next = (!cv.run || cv.step) ? 7'h00 : cnt_reg + 7'h01;
	assign idx_next = (!cv.run || cv.done) ? 4'h0 : (cv.step ? idx_reg + 4'h1 : idx_reg);

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cnt_reg <= 7'h00;
			idx_reg <= 4'h0;
		end else begin
			cnt_reg <= cnt_next;
			idx_reg <= idx_next;
		end
	end
endmodule
`default_nettype wire

// ### rtl/sac_sar.sv
`default_nettype none
module sac_sar
	import sac_pkg::*;
(
	// clock and reset
	input  wire logic      sys_clk,
	input  wire logic      resetn,
	// approximation datapath
	sac_conv_if.sar        cv
);
	logic [9:0] work_reg;
	logic [9:0] work_next;
	logic       deciding;
	logic [3:0] bit_pos;
	logic [9:0] mask;
	logic [9:0] decided;

	// first steps hold the input, then one bit per step, msb first
	assign deciding = cv.step_idx >= 4'(SAMPLE_STEPS);
	assign bit_pos  = 4'(RES_BITS - 1 + SAMPLE_STEPS) - cv.step_idx;
	assign mask     = deciding ? (10'h001 << bit_pos) : 10'h000;
	assign cv.trial = work_reg | mask;
	assign decided  = cv.cmp_bit ? cv.trial : work_reg;
	assign cv.final_code = decided;
	assign cv.sampling   = cv.run && !deciding;

	assign work_next = !cv.run ? 10'h000 :
		(cv.step && cv.step_idx == 4'(SAR_STEPS - 1)) ? 10'h000 :
		(cv.step && deciding) ? decided : work_reg;

	always_ff @(posedge sys_clk) begin
		if (!resetn)
			work_reg <= 10'h000;
		else
			work_reg <= work_next;
	end
endmodule
`default_nettype wire

// ### rtl/sac_top.sv
`default_nettype none
module sac_top
	import sac_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// power management, high in stop, slow and sleep
	input  wire logic       standby_mode,
	// analog front end
	input  wire logic       cmp_in,
	output logic      [3:0] channel_select_field,
	output logic            analog_input_disable,
	output logic            ladder_connect,
	output logic            sample_hold,
	output logic      [9:0] dac_code,
	// event
	output logic            conversion_done_interrupt
);
	sac_conv_if cv ();

	sac_pace u_pace (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.cv      (cv.pace)
	);

	sac_sar u_sar (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.cv      (cv.sar)
	);

	sac_state_t state_reg;
	sac_state_t state_next;
	logic [7:0] ctl1_reg;
	logic [7:0] ctl1_next;
	logic [7:0] ctl2_reg;
	logic [7:0] ctl2_next;
	logic       eoc_reg;
	logic       eoc_next;
	logic [9:0] res_reg;
	logic [9:0] res_next;
	logic [6:0] per_reg;
	logic [6:0] per_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic       irq_reg;
	logic       ladder_reg;
	logic [9:0] dac_reg;
	logic       sh_reg;
	logic       cmp_s1_reg;
	logic       cmp_s2_reg;

	logic       wr_c1;
	logic       wr_c2;
	logic       rd_res;
	sac_mode_t  mode;
	logic       mode_ok;
	logic       busy;
	logic       go;
	logic       stop;
	logic       done_ok;
	logic       cont;
	logic [7:0] status_val;
	logic [7:0] read_mux;
	logic [3:0] nidx;
	logic [9:0] nmask;
	logic [9:0] dac_next;

	// address decode; low-power mode shuts the control registers to writes
	assign wr_c1  = reg_wr && reg_addr == ADDR_CTL_ONE && !standby_mode;
	assign wr_c2  = reg_wr && reg_addr == ADDR_CTL_TWO && !standby_mode;
	assign rd_res = reg_rd && reg_addr == ADDR_RES_HIGH;

	assign mode    = sac_mode_t'(ctl1_reg[C1_MODE_LSB +: 2]);
	assign mode_ok = mode == MODE_SINGLE || mode == MODE_REPEAT;
	assign busy    = state_reg == ST_CONV;

	assign go   = ctl1_reg[C1_START_BIT] && !busy && mode_ok && !standby_mode;
	assign stop = busy && (standby_mode || !mode_ok);
	// completion only counts when nothing aborts it
	assign done_ok = cv.done && busy && mode_ok && !standby_mode;
	assign cont    = done_ok && mode == MODE_REPEAT;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (go)
					state_next = ST_CONV;
			end
			ST_CONV: begin
				if (stop || (done_ok && !cont))
					state_next = ST_IDLE;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	assign ctl1_next = standby_mode ? CTL_ONE_RST :
		wr_c1 ? reg_wdata :
		(!busy ? (ctl1_reg & ~(8'h01 << C1_START_BIT)) : ctl1_reg);
	assign ctl2_next = standby_mode ? CTL_TWO_RST : (wr_c2 ? reg_wdata : ctl2_reg);

	assign per_next = (go || cont) ? sac_period(ctl2_reg[C2_TIME_LSB +: 3]) : per_reg;

	// end flag: completion wins over the clearing read
	assign eoc_next = standby_mode ? 1'b0 : (done_ok ? 1'b1 : (rd_res ? 1'b0 : eoc_reg));
	assign res_next = standby_mode ? 10'h000 : (done_ok ? cv.final_code : res_reg);

	// status layout; low nibble reads zero
	assign status_val = {res_reg[1:0], eoc_reg, busy, 4'h0};
	// top bits of control two read as zero here
	assign read_mux =
		reg_addr == ADDR_CTL_ONE  ? ctl1_reg :
		reg_addr == ADDR_CTL_TWO  ? {2'b00, ctl2_reg[5:0]} :
		reg_addr == ADDR_STATUS   ? status_val :
		reg_addr == ADDR_RES_HIGH ? res_reg[9:2] : 8'h00;
	assign rdata_next = reg_rd ? read_mux : 8'h00;

	assign cv.run     = busy;
	assign cv.period  = per_reg;
	assign cv.cmp_bit = cmp_s2_reg;

	// next trial goes out on the step edge itself: with the dac flop and
	// two comparator flops, a three-cycle step still decides on its own trial
	assign nidx     = cv.step_idx + 4'h1;
	assign nmask    = (nidx >= 4'(SAMPLE_STEPS) && nidx < 4'(SAR_STEPS)) ?
		(10'h001 << (4'(RES_BITS - 1 + SAMPLE_STEPS) - nidx)) : 10'h000;
	assign dac_next = !cv.step ? cv.trial :
		((nidx == 4'(SAR_STEPS)) ? 10'h000 : (cv.final_code | nmask));

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			ctl1_reg  <= CTL_ONE_RST;
			ctl2_reg  <= CTL_TWO_RST;
			eoc_reg   <= 1'b0;
			res_reg   <= 10'h000;
			per_reg   <= 7'h00;
			rdata_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			ctl1_reg  <= ctl1_next;
			ctl2_reg  <= ctl2_next;
			eoc_reg   <= eoc_next;
			res_reg   <= res_next;
			per_reg   <= per_next;
			rdata_reg <= rdata_next;
		end
	end

	// comparator is asynchronous to the sequencer, so two stages before use
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cmp_s1_reg <= 1'b0;
			cmp_s2_reg <= 1'b0;
		end else begin
			cmp_s1_reg <= cmp_in;
			cmp_s2_reg <= cmp_s1_reg;
		end
	end

	// analog-side drives are registered to keep glitches off the front end
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			irq_reg    <= 1'b0;
			ladder_reg <= 1'b0;
			dac_reg    <= 10'h000;
			sh_reg     <= 1'b0;
		end else begin
			irq_reg    <= done_ok;
			ladder_reg <= !standby_mode &&
				(ctl2_next[C2_LADDER_BIT] || state_next == ST_CONV);
			dac_reg    <= dac_next;
			sh_reg     <= cv.sampling;
		end
	end

	assign reg_rdata                 = rdata_reg;
	assign channel_select_field      = ctl1_reg[C1_CHAN_LSB +: 4];
	assign analog_input_disable      = ctl1_reg[C1_INDIS_BIT];
	assign ladder_connect            = ladder_reg;
	assign sample_hold               = sh_reg;
	assign dac_code                  = dac_reg;
	assign conversion_done_interrupt = irq_reg;

	// helper: cycles spent busy in the current conversion
	logic [10:0] bcnt_reg;
	always_ff @(posedge sys_clk) begin
		if (!resetn || !busy || done_ok)
			bcnt_reg <= 11'h000;
		else
			bcnt_reg <= bcnt_reg + 11'h001;
	end

	property p_start;
		@(posedge sys_clk) disable iff (!resetn)
		go && !wr_c1 |=> busy && !ctl1_reg[C1_START_BIT];
	endproperty
	a_start: assert property (p_start) else $error("start not taken or not cleared");

	property p_standby_busy;
		@(posedge sys_clk) disable iff (!resetn)
		standby_mode |=> !busy && !eoc_reg && res_reg == 10'h000;
	endproperty
	a_standby_busy: assert property (p_standby_busy) else $error("standby left activity");

	property p_standby_ctl;
		@(posedge sys_clk) disable iff (!resetn)
		standby_mode ##1 standby_mode |-> ctl1_reg == CTL_ONE_RST && ctl2_reg == CTL_TWO_RST;
	endproperty
	a_standby_ctl: assert property (p_standby_ctl) else $error("control not held at init");

	property p_done;
		@(posedge sys_clk) disable iff (!resetn)
		done_ok |=> eoc_reg && conversion_done_interrupt
			&& res_reg == $past(cv.final_code);
	endproperty
	a_done: assert property (p_done) else $error("completion effects not together");

	property p_irq_pulse;
		@(posedge sys_clk) disable iff (!resetn)
		conversion_done_interrupt |=> !conversion_done_interrupt;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt not a pulse");

	property p_read_clear;
		@(posedge sys_clk) disable iff (!resetn)
		rd_res && !done_ok |=> !eoc_reg;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("end flag not cleared by read");

	property p_repeat;
		@(posedge sys_clk) disable iff (!resetn)
		done_ok && mode == MODE_REPEAT |=> busy && eoc_reg && cv.step_idx == 4'h0;
	endproperty
	a_repeat: assert property (p_repeat) else $error("repeat did not continue");

	property p_mode_off;
		@(posedge sys_clk) disable iff (!resetn)
		busy && mode == MODE_OFF && !standby_mode |=> !busy && $stable(res_reg);
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("disable did not stop cleanly");

	property p_length;
		@(posedge sys_clk) disable iff (!resetn)
		done_ok |-> bcnt_reg + 11'h001 == 11'(per_reg) * 11'(SAR_STEPS);
	endproperty
	a_length: assert property (p_length) else $error("conversion length wrong");

	property p_ladder;
		@(posedge sys_clk) disable iff (!resetn)
		busy |-> ladder_connect;
	endproperty
	a_ladder: assert property (p_ladder) else $error("ladder open while converting");

	property p_status;
		@(posedge sys_clk) disable iff (!resetn)
		reg_rd && reg_addr == ADDR_STATUS |=>
			reg_rdata[7:4] == {$past(res_reg[1:0]), $past(eoc_reg), $past(busy)};
	endproperty
	a_status: assert property (p_status) else $error("status layout wrong");

	property p_mode_drop;
		@(posedge sys_clk) disable iff (!resetn)
		ctl1_reg[C1_START_BIT] && !busy && !mode_ok && !wr_c1 |=>
			!busy && !ctl1_reg[C1_START_BIT];
	endproperty
	a_mode_drop: assert property (p_mode_drop) else $error("start taken in a stopped mode");

	property p_no_start;
		@(posedge sys_clk) disable iff (!resetn)
		!busy && !go |=> !busy;
	endproperty
	a_no_start: assert property (p_no_start) else $error("conversion began without a start");

	property p_busy_hold;
		@(posedge sys_clk) disable iff (!resetn)
		busy && !stop && !cv.done |=> busy;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped before the end");

	property p_res_hold;
		@(posedge sys_clk) disable iff (!resetn)
		!done_ok && !standby_mode |=> $stable(res_reg);
	endproperty
	a_res_hold: assert property (p_res_hold) else $error("result changed without completion");

	property p_eoc_src;
		@(posedge sys_clk) disable iff (!resetn)
		!done_ok |=> !$rose(eoc_reg);
	endproperty
	a_eoc_src: assert property (p_eoc_src) else $error("end flag rose without completion");

	property p_sh_busy;
		@(posedge sys_clk) disable iff (!resetn)
		sample_hold |-> $past(busy);
	endproperty
	a_sh_busy: assert property (p_sh_busy) else $error("sampling outside a conversion");

	property p_standby_ladder;
		@(posedge sys_clk) disable iff (!resetn)
		standby_mode |=> !ladder_connect;
	endproperty
	a_standby_ladder: assert property (p_standby_ladder) else $error("ladder on in standby");
endmodule
`default_nettype wire

// ### testbench/testbench.sv
`default_nettype none
module testbench
	import sac_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;

	logic       sys_clk;
	logic       resetn;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       standby_mode;
	logic       cmp_in;
	logic [3:0] channel_select_field;
	logic       analog_input_disable;
	logic       ladder_connect;
	logic       sample_hold;
	logic [9:0] dac_code;
	logic       conversion_done_interrupt;
	logic [9:0] target;
	logic [7:0] d;
	logic [9:0] t;
	sac_mode_t  md;
	int         n;
	int         n_mismatch;
	int         n_checks;

	sac_top i_dut (
		.sys_clk                   (sys_clk),
		.resetn                    (resetn),
		.reg_addr                  (reg_addr),
		.reg_wdata                 (reg_wdata),
		.reg_wr                    (reg_wr),
		.reg_rd                    (reg_rd),
		.reg_rdata                 (reg_rdata),
		.standby_mode              (standby_mode),
		.cmp_in                    (cmp_in),
		.channel_select_field      (channel_select_field),
		.analog_input_disable      (analog_input_disable),
		.ladder_connect            (ladder_connect),
		.sample_hold               (sample_hold),
		.dac_code                  (dac_code),
		.conversion_done_interrupt (conversion_done_interrupt)
	);

	// ideal comparator: the sampled input sits at target, so the result must equal it
	assign cmp_in = (target >= dac_code);

	always #25 sys_clk = ~sys_clk;

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	// n counts cycles after the write edge; 0 means no pulse within bound
	task automatic wait_irq(input int bound, input logic must, input logic fe, output int n);
		n = 0;
		for (int i = 1; i <= bound; i++) begin
			@(posedge sys_clk);
			#1;
			if (fe && i == 1) chk(ladder_connect, 1'b1);
			if (fe && i == 2) chk(sample_hold, 1'b1);
			if (conversion_done_interrupt === 1'b1) begin
				n = i;
				break;
			end
		end
		if (must && n == 0) begin
			n_mismatch++;
			test_done();
		end
	endtask

	function automatic int conv_time(input logic [2:0] c);
		case (c)
			3'b000: return CONV_CYC_0;
			3'b010: return CONV_CYC_2;
			3'b011: return CONV_CYC_3;
			3'b100: return CONV_CYC_4;
			3'b101: return CONV_CYC_5;
			default: return CONV_CYC_6;
		endcase
	endfunction

	function automatic logic [9:0] tgt_of(input int k);
		if (k == 0) return 10'h3ff;
		if (k == 7) return 10'h000;
		return 10'(k * 165);
	endfunction

	initial begin
		sys_clk = 1'b0;
		resetn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		standby_mode = 1'b0;
		target = 10'h000;
		n_mismatch = 0;
		n_checks = 0;
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(ADDR_CTL_ONE, d);
		chk(d, CTL_ONE_RST);
		chk(analog_input_disable, 1'b1);
		rd(ADDR_STATUS, d);
		chk(d & 8'hf0, 8'h00);
		rd(8'h40, d);
		chk(d, 8'h00);
		// each code with channels 0 to 7, set while idle bit 4 set, bit 0 clear
		for (int k = 0; k < 8; k++) begin
			t = tgt_of(k);
			target <= t;
			wr(ADDR_CTL_TWO, {2'b00, k == 7, 1'b1, 3'(k), 1'b0});
			rd(ADDR_CTL_TWO, d);
			chk(d & 8'h3f, {2'b00, k == 7, 1'b1, 3'(k), 1'b0});
			wr(ADDR_CTL_ONE, {1'b1, MODE_SINGLE, 1'b0, 4'(k)});
			chk(channel_select_field, 4'(k));
			chk(analog_input_disable, 1'b0);
			wait_irq(1300, 1'b1, 1'b1, n);
			chk(16'(n), 16'(conv_time(3'(k)) + 1));
			rd(ADDR_STATUS, d);
			chk(d & 8'hf0, {t[1:0], 2'b10, 4'h0});
			rd(ADDR_RES_HIGH, d);
			chk(d, t[9:2]);
			rd(ADDR_STATUS, d);
			chk(d & 8'hf0, {t[1:0], 2'b00, 4'h0});
			rd(ADDR_CTL_ONE, d);
			chk(d, {1'b0, MODE_SINGLE, 1'b0, 4'(k)});
			chk(ladder_connect, k == 7);
		end
		// a start under disabled or reserved mode is dropped
		for (int m = 0; m < 2; m++) begin
			md = (m == 0) ? MODE_OFF : MODE_RSVD;
			wr(ADDR_CTL_ONE, {1'b1, md, 1'b0, 4'h2});
			wait_irq(60, 1'b0, 1'b0, n);
			chk(16'(n), 16'h0000);
			rd(ADDR_CTL_ONE, d);
			chk(d, {1'b0, md, 1'b0, 4'h2});
		end
		target <= 10'h1c6;
		wr(ADDR_CTL_TWO, 8'h10);
		wr(ADDR_CTL_ONE, {1'b1, MODE_REPEAT, 1'b0, 4'h5});
		wait_irq(100, 1'b1, 1'b1, n);
		chk(16'(n), 16'(CONV_CYC_0 + 1));
		wait_irq(100, 1'b1, 1'b0, n);
		chk(16'(n), 16'(CONV_CYC_0));
		rd(ADDR_STATUS, d);
		chk(d & 8'h30, 8'h30);
		// the stopped conversion would produce a different code
		target <= 10'h039;
		wr(ADDR_CTL_ONE, {1'b0, MODE_OFF, 1'b0, 4'h5});
		wait_irq(100, 1'b0, 1'b0, n);
		chk(16'(n), 16'h0000);
		rd(ADDR_STATUS, d);
		chk(d & 8'hf0, 8'ha0);
		rd(ADDR_RES_HIGH, d);
		chk(d, 8'h71);
		wr(ADDR_RES_HIGH, 8'h00);
		rd(ADDR_RES_HIGH, d);
		chk(d, 8'h71);
		// standby entry mid-conversion, long time code and ladder always on
		wr(ADDR_CTL_TWO, 8'h3c);
		wr(ADDR_CTL_ONE, {1'b1, MODE_SINGLE, 1'b0, 4'h7});
		rd(ADDR_STATUS, d);
		chk(d & 8'h10, 8'h10);
		@(posedge sys_clk);
		standby_mode <= 1'b1;
		wr(ADDR_CTL_ONE, 8'h27);
		rd(ADDR_CTL_ONE, d);
		chk(d, CTL_ONE_RST);
		rd(ADDR_CTL_TWO, d);
		chk(d & 8'h3f, CTL_TWO_RST & 8'h3f);
		rd(ADDR_STATUS, d);
		chk(d & 8'hf0, 8'h00);
		rd(ADDR_RES_HIGH, d);
		chk(d, 8'h00);
		chk(ladder_connect, 1'b0);
		@(posedge sys_clk);
		standby_mode <= 1'b0;
		wait_irq(1300, 1'b0, 1'b0, n);
		chk(16'(n), 16'h0000);
		test_done();
	end
endmodule
`default_nettype wire
